// ===== rtl/pgc_timebase.sv
// generator C timebase, reload logic, registers and deadtime pair
`timescale 1ns/1ps
// Notes on behaviour
// - frequency, modulus and deadtime writes only accepted in multi-generator mode
// - reload once every field-plus-one opportunities
// - new reload frequency applies after current load cycle, ignoring load-okay
// - reload frequency reads return the buffered value
// - half-cycle bit adds reloads in center-aligned mode only
// - prescaler divides bus clock by 1, 2, 4 or 8
// - prescaler buffered, applied at next reload only with load-okay set
// - reload flag sets at every reload cycle
// - flag clears by reading it set then writing one
// - a reload between that read and write keeps the flag set
// - clearing the flag withdraws the pending interrupt request
// - counter register is read-only and shows the live counter
// - modulus is a 15-bit period in PWM clocks in edge-aligned mode, half the period in center-aligned mode
// - modulus buffered, used after load-okay at next load cycle
// - deadtime writes ignored once write-protect is set
// - deadtime is 12 bits, reset to 0x0FFF
// - deadtime lasts divisor times count minus one; divisor one gives count
// - load-okay set by read-zero-then-write-one, cleared at reload or by zero
// - interrupt request raised only while reload interrupt enable is set
// - generator C runs only in multi-generator mode
module pgc_timebase (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic [pgc_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [pgc_pkg::DATA_W-1:0] wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [pgc_pkg::ADDR_W-1:0] araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [pgc_pkg::DATA_W-1:0]      rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	input  wire logic                       pairDrive,
	output logic                            pwmTop,
	output logic                            pwmBot,
	output logic                            reloadIrq
);
	import pgc_pkg::*;

	logic [ADDR_W-1:0] awAddr_q;
	logic              awHeld_q;
	logic [DATA_W-1:0] wData_q;
	logic [3:0]        wStrb_q;
	logic              wHeld_q;
	logic              awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
	logic [1:0]        bResp_q, rResp_q;
	logic [DATA_W-1:0] rData_q;
	logic              mtg_q, genEn_q, edge_q, ldok_q, irqEn_q, wp_q;
	logic              ldokArm_q, flag_q, flagArm_q, half_q;
	logic [3:0]        ldfqBuf_q, ldfqAct_q, oppCnt_q;
	logic [1:0]        prscBuf_q, prscAct_q;
	logic [14:0]       modBuf_q, modAct_q, cnt_q;
	logic [11:0]       dtm_q;
	logic [2:0]        divCnt_q;
	pgc_dir_t          dir_q;
	logic              drvLast_q, top_q, bot_q, irq_q;
	logic [15:0]       dtCnt_q;

	logic              wrDo, arTake, running, tick, wrap, topEv, botEv;
	logic              opp, reloadEv, lane0, lane1, flagClr, mapW, mapR;
	logic [5:0]        wIdx, rIdx;
	logic [2:0]        divMax;
	logic [15:0]       prod, dtCycles;
	logic [DATA_W-1:0] rdMux;

	assign wrDo    = awHeld_q && wHeld_q && !bValid_q;
	assign arTake  = arvalid && arReady_q;
	assign wIdx    = awAddr_q[7:2];
	assign rIdx    = araddr[7:2];
	assign lane0   = wStrb_q[0];
	assign lane1   = wStrb_q[1];
	assign running = mtg_q && genEn_q;
	assign mapW    = wIdx == IDX_FQC || wIdx == IDX_CNT || wIdx == IDX_MOD
		|| wIdx == IDX_DTM || wIdx == IDX_CTRL;
	assign mapR    = rIdx == IDX_FQC || rIdx == IDX_CNT || rIdx == IDX_MOD
		|| rIdx == IDX_DTM || rIdx == IDX_CTRL;

	// write address and data taken in either order, answered together
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awAddr_q  <= '0;
			awHeld_q  <= 1'b0;
			awReady_q <= 1'b1;
		end else if (awvalid && awReady_q) begin
			awAddr_q  <= awaddr;
			awHeld_q  <= 1'b1;
			awReady_q <= 1'b0;
		end else if (bValid_q && bready) begin
			awHeld_q  <= 1'b0;
			awReady_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wData_q  <= '0;
			wStrb_q  <= '0;
			wHeld_q  <= 1'b0;
			wReady_q <= 1'b1;
		end else if (wvalid && wReady_q) begin
			wData_q  <= wdata;
			wStrb_q  <= wstrb;
			wHeld_q  <= 1'b1;
			wReady_q <= 1'b0;
		end else if (bValid_q && bready) begin
			wHeld_q  <= 1'b0;
			wReady_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bValid_q <= 1'b0;
			bResp_q  <= RESP_OKAY;
		end else if (wrDo) begin
			bValid_q <= 1'b1;
			bResp_q  <= mapW ? RESP_OKAY : RESP_SLVERR;
		end else if (bValid_q && bready) begin
			bValid_q <= 1'b0;
		end
	end

	// read answer one cycle after the address is taken
	always_comb begin
		rdMux = '0;
		case (rIdx)
			IDX_FQC: begin
				rdMux[FQC_LDFQ +: 4] = ldfqBuf_q;
				rdMux[FQC_HALF]      = half_q;
				rdMux[FQC_PRSC +: 2] = prscBuf_q;
				rdMux[FQC_FLAG]      = flag_q;
			end
			IDX_CNT: rdMux[14:0] = cnt_q;
			IDX_MOD: rdMux[14:0] = modBuf_q;
			IDX_DTM: rdMux[11:0] = dtm_q;
			IDX_CTRL: begin
				rdMux[CTL_MTG]    = mtg_q;
				rdMux[CTL_GEN_EN] = genEn_q && mtg_q;
				rdMux[CTL_EDGE]   = edge_q;
				rdMux[CTL_LDOK]   = ldok_q && mtg_q;
				rdMux[CTL_IRQ_EN] = irqEn_q && mtg_q;
				rdMux[CTL_WP]     = wp_q;
			end
			default: rdMux = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arReady_q <= 1'b1;
			rValid_q  <= 1'b0;
			rData_q   <= '0;
			rResp_q   <= RESP_OKAY;
		end else if (arTake) begin
			arReady_q <= 1'b0;
			rValid_q  <= 1'b1;
			rData_q   <= rdMux;
			rResp_q   <= mapR ? RESP_OKAY : RESP_SLVERR;
		end else if (rValid_q && rready) begin
			arReady_q <= 1'b1;
			rValid_q  <= 1'b0;
		end
	end

	// control register; write-protect only ever sets
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mtg_q   <= 1'b0;
			genEn_q <= 1'b0;
			edge_q  <= 1'b0;
			irqEn_q <= 1'b0;
			wp_q    <= 1'b0;
		end else if (wrDo && wIdx == IDX_CTRL && lane0) begin
			mtg_q  <= wData_q[CTL_MTG];
			edge_q <= wData_q[CTL_EDGE];
			wp_q   <= wp_q || wData_q[CTL_WP];
			if (mtg_q) begin
				genEn_q <= wData_q[CTL_GEN_EN];
				irqEn_q <= wData_q[CTL_IRQ_EN];
			end
		end
	end

	// load-okay needs a read of zero before a one sticks
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ldok_q    <= 1'b0;
			ldokArm_q <= 1'b0;
		end else if (wrDo && wIdx == IDX_CTRL && lane0 && mtg_q) begin
			ldokArm_q <= 1'b0;
			if (!wData_q[CTL_LDOK])
				ldok_q <= 1'b0;
			else if (ldokArm_q)
				ldok_q <= 1'b1;
			else if (reloadEv)
				ldok_q <= 1'b0;
		end else begin
			if (reloadEv)
				ldok_q <= 1'b0;
			if (arTake && rIdx == IDX_CTRL && mtg_q && !ldok_q)
				ldokArm_q <= 1'b1;
		end
	end

	// written fields of frequency control, modulus buffer and deadtime (deadtime used directly)
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ldfqBuf_q <= LDFQ_RST;
			half_q    <= 1'b0;
			prscBuf_q <= PRSC_RST;
			modBuf_q  <= MOD_RST;
			dtm_q     <= DT_RST;
		end else if (wrDo && mtg_q) begin
			if (wIdx == IDX_FQC && lane0) begin
				ldfqBuf_q <= wData_q[FQC_LDFQ +: 4];
				half_q    <= wData_q[FQC_HALF];
				prscBuf_q <= wData_q[FQC_PRSC +: 2];
			end
			if (wIdx == IDX_MOD) begin
				if (lane0)
					modBuf_q[7:0] <= wData_q[7:0];
				if (lane1)
					modBuf_q[14:8] <= wData_q[14:8];
			end
			if (wIdx == IDX_DTM && !wp_q) begin
				if (lane0)
					dtm_q[7:0] <= wData_q[7:0];
				if (lane1)
					dtm_q[11:8] <= wData_q[11:8];
			end
		end
	end

	// prescaler
	always_comb begin
		case (prscAct_q)
			2'h0: divMax = 3'h0;
			2'h1: divMax = 3'h1;
			2'h2: divMax = 3'h3;
			default: divMax = 3'h7;
		endcase
	end
	assign tick = running && divCnt_q == divMax;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			divCnt_q <= '0;
		else if (!running || tick)
			divCnt_q <= '0;
		else
			divCnt_q <= divCnt_q + 3'h1;
	end

	// counter events; zero modulus is the caller's fault and not guarded
	assign wrap  = tick && edge_q && cnt_q + 15'h0001 >= modAct_q;
	assign topEv = tick && !edge_q && dir_q == CNT_UP && cnt_q >= modAct_q;
	// bottom fires on leaving zero, like top on leaving modulus: even halves
	assign botEv = tick && !edge_q && dir_q == CNT_DOWN
		&& cnt_q == 15'h0000;
	assign opp      = wrap || botEv || (topEv && half_q);
	assign reloadEv = opp && oppCnt_q == ldfqAct_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			dir_q <= CNT_UP;
		end else if (!running) begin
			cnt_q <= '0;
			dir_q <= CNT_UP;
		end else if (tick) begin
			if (wrap) begin
				cnt_q <= '0;
			end else if (edge_q) begin
				cnt_q <= cnt_q + 15'h0001;
			end else if (topEv) begin
				cnt_q <= cnt_q - 15'h0001;
				dir_q <= CNT_DOWN;
			end else if (botEv) begin
				cnt_q <= 15'h0001;
				dir_q <= CNT_UP;
			end else if (dir_q == CNT_UP) begin
				cnt_q <= cnt_q + 15'h0001;
			end else begin
				cnt_q <= cnt_q - 15'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			oppCnt_q <= '0;
		else if (!running || reloadEv)
			oppCnt_q <= '0;
		else if (opp)
			oppCnt_q <= oppCnt_q + 4'h1;
	end

	// values in use change only at a reload
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ldfqAct_q <= LDFQ_RST;
			prscAct_q <= PRSC_RST;
			modAct_q  <= MOD_RST;
		end else if (reloadEv) begin
			ldfqAct_q <= ldfqBuf_q;
			if (ldok_q) begin
				prscAct_q <= prscBuf_q;
				modAct_q  <= modBuf_q;
			end
		end
	end

	// reload flag: a reload wins over a clear in the same cycle
	assign flagClr = wrDo && mtg_q && wIdx == IDX_FQC && lane0
		&& wData_q[FQC_FLAG] && flagArm_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag_q    <= 1'b0;
			flagArm_q <= 1'b0;
		end else begin
			if (reloadEv)
				flag_q <= 1'b1;
			else if (flagClr)
				flag_q <= 1'b0;
			if (reloadEv)
				flagArm_q <= 1'b0;
			else if (arTake && rIdx == IDX_FQC && flag_q)
				flagArm_q <= 1'b1;
			else if (wrDo && wIdx == IDX_FQC)
				flagArm_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			irq_q <= 1'b0;
		else
			irq_q <= flag_q && irqEn_q && mtg_q;
	end

	// deadtime in bus clocks; divisor one is the exact count
	assign prod = {13'h0000, divMax} * 16'h0001 + 16'h0001;
	always_comb begin
		dtCycles = 16'(prod * {4'h0, dtm_q});
		if (dtm_q == 12'h000)
			dtCycles = '0;
		else if (divMax != 3'h0)
			dtCycles = dtCycles - 16'h0001;
	end

	// both switches off while the timer is stopped, so no shoot-through
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			drvLast_q <= 1'b0;
			dtCnt_q   <= '0;
			top_q     <= 1'b0;
			bot_q     <= 1'b0;
		end else if (!running) begin
			drvLast_q <= pairDrive;
			dtCnt_q   <= '0;
			top_q     <= 1'b0;
			bot_q     <= 1'b0;
		end else begin
			drvLast_q <= pairDrive;
			if (pairDrive != drvLast_q && dtCycles != 16'h0000) begin
				dtCnt_q <= dtCycles - 16'h0001;
				top_q   <= 1'b0;
				bot_q   <= 1'b0;
			end else if (dtCnt_q != 16'h0000) begin
				dtCnt_q <= dtCnt_q - 16'h0001;
				top_q   <= 1'b0;
				bot_q   <= 1'b0;
			end else begin
				top_q <= pairDrive;
				bot_q <= !pairDrive;
			end
		end
	end

	assign awready   = awReady_q;
	assign wready    = wReady_q;
	assign bvalid    = bValid_q;
	assign bresp     = bResp_q;
	assign arready   = arReady_q;
	assign rvalid    = rValid_q;
	assign rdata     = rData_q;
	assign rresp     = rResp_q;
	assign pwmTop    = top_q;
	assign pwmBot    = bot_q;
	assign reloadIrq = irq_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_write_gate_mod: assert property (
		wrDo && !mtg_q |=> $stable(modBuf_q) && $stable(dtm_q))
		else $error("write accepted without multi-generator mode");
	a_ldfq_apply: assert property (
		reloadEv |=> ldfqAct_q == $past(ldfqBuf_q))
		else $error("reload frequency not applied at reload");
	a_prsc_hold: assert property (
		!(reloadEv && ldok_q) |=> $stable(prscAct_q) && $stable(modAct_q))
		else $error("prescaler or modulus changed outside a loaded reload");
	a_mod_apply: assert property (
		reloadEv && ldok_q |=> modAct_q == $past(modBuf_q))
		else $error("modulus not applied at loaded reload");
	a_flag_set: assert property (
		reloadEv |=> flag_q)
		else $error("reload flag not set by reload");
	a_flag_keep: assert property (
		flag_q && !flagArm_q |=> flag_q)
		else $error("reload flag cleared without a valid sequence");
	a_irq_gated: assert property (
		reloadIrq |-> $past(flag_q) && $past(irqEn_q))
		else $error("interrupt raised without flag and enable");
	a_wp_lock: assert property (
		wp_q |=> $stable(dtm_q) && wp_q)
		else $error("deadtime changed after write protect");
	a_ldok_clear: assert property (
		reloadEv && !(wrDo && wIdx == IDX_CTRL) |=> !ldok_q)
		else $error("load-okay not cleared at reload");
	a_dt_off: assert property (
		running && pairDrive != drvLast_q && dtCycles > 16'h0001
		|=> (!pwmTop && !pwmBot)[*2])
		else $error("pair not held off during deadtime");
endmodule

// ===== rtl/pgc_pkg.sv
// constants for the generator C timebase and configuration block
package pgc_pkg;
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam int          CNT_W       = 15;
	localparam int          DT_W        = 12;
	// register indices; byte address is four times the index
	localparam logic [5:0]  IDX_FQC     = 6'h31;
	localparam logic [5:0]  IDX_CNT     = 6'h32;
	localparam logic [5:0]  IDX_MOD     = 6'h34;
	localparam logic [5:0]  IDX_DTM     = 6'h36;
	localparam logic [5:0]  IDX_CTRL    = 6'h38;
	// frequency control fields
	localparam int          FQC_FLAG    = 0;
	localparam int          FQC_PRSC    = 1;
	localparam int          FQC_HALF    = 3;
	localparam int          FQC_LDFQ    = 4;
	// control register fields
	localparam int          CTL_MTG     = 0;
	localparam int          CTL_GEN_EN  = 1;
	localparam int          CTL_EDGE    = 2;
	localparam int          CTL_LDOK    = 3;
	localparam int          CTL_IRQ_EN  = 4;
	localparam int          CTL_WP      = 5;
	// reset values and response codes
	localparam logic [11:0] DT_RST      = 12'h0fff;
	localparam logic [14:0] MOD_RST     = 15'h0001;
	localparam logic [3:0]  LDFQ_RST    = 4'h0;
	localparam logic [1:0]  PRSC_RST    = 2'h0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic {
		CNT_UP   = 1'b0,
		CNT_DOWN = 1'b1
	} pgc_dir_t;
endpackage

// ===== verification/pgc_gate_model.sv
// gate driver model for the top and bottom switches of pair C
`timescale 1ns/1ps
module pgc_gate_model (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic gateTop,
	input  wire logic gateBot,
	output logic      shootThru
);
	// sticky, so one overlapping cycle is never lost
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			shootThru <= 1'b0;
		else if (gateTop && gateBot)
			shootThru <= 1'b1;
	end
endmodule

// ===== verification/tb_pgc_timebase.sv
// self-checking bench for the generator C timebase block
`timescale 1ns/1ps
module tb_pgc_timebase;
	import pgc_pkg::*;
	logic              clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              pairDrive, pwmTop, pwmBot, reloadIrq, shootThru;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	int                fail_count, checked, cyc, a, b, n;

	pgc_timebase uut (.clk(clk), .rstn(rstn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pairDrive(pairDrive), .pwmTop(pwmTop),
		.pwmBot(pwmBot), .reloadIrq(reloadIrq));
	pgc_gate_model gates (.clk(clk), .rstn(rstn), .gateTop(pwmTop),
		.gateBot(pwmBot), .shootThru(shootThru));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic close_out;
		$display("comparisons %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// address and data released on their own handshakes
	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awready === 1'b1) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && wready === 1'b1) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, bresp});
	endtask

	task automatic rd(input logic [5:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rc(input string what, input logic [5:0] idx,
		input logic [15:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(idx, d, r);
		chk(what, {16'h0000, exp}, d);
	endtask

	// sampled after the edge so a level about to fall is not taken
	task automatic wait_irq;
		@(posedge clk);
		#1;
		while (reloadIrq !== 1'b1) begin
			@(posedge clk);
			#1;
		end
	endtask

	// cycles with both gates off after pairDrive moves to lvl
	task automatic dtime(input logic lvl, output int cnt);
		cnt = 0;
		@(posedge clk);
		pairDrive <= lvl;
		@(posedge clk);
		#1;
		while (!(pwmTop === lvl && pwmBot === !lvl) && cnt < 100) begin
			cnt++;
			@(posedge clk);
			#1;
		end
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rc("freq ctl", IDX_FQC, 16'h0000);
		rc("counter", IDX_CNT, 16'h0000);
		rc("modulus", IDX_MOD, 16'h0001);
		rc("deadtime", IDX_DTM, 16'h0fff);
		rd(6'h3a, d, r);
		chk("unmapped resp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, r});
	endtask

	task automatic t_gate;
		wr(IDX_MOD, 16'h0005);
		rc("modulus locked", IDX_MOD, 16'h0001);
		wr(IDX_CTRL, 16'h0001);
		wr(IDX_MOD, 16'h0064);
		rc("modulus buffer", IDX_MOD, 16'h0064);
		wr(IDX_CNT, 16'h0055);
		rc("counter ro", IDX_CNT, 16'h0000);
		wr(IDX_DTM, 16'h0003);
		wr(IDX_FQC, 16'h00f0);
	endtask

	task automatic t_flag;
		logic [31:0] d;
		logic [1:0]  r;
		rd(IDX_CTRL, d, r);
		wr(IDX_CTRL, 16'h001f);
		wait_irq();
		rd(IDX_FQC, d, r);
		wr(IDX_FQC, 16'h00f9);
		wait_irq();
		a = cyc;
		rc("flag set", IDX_FQC, 16'h00f9);
		wr(IDX_FQC, 16'h00f9);
		rc("flag clear", IDX_FQC, 16'h00f8);
		chk("irq withdrawn", 32'h0000_0000, {31'h0000_0000, reloadIrq});
		wait_irq();
		b = cyc;
		chk("reload spacing", 32'd1600, b - a);
		rd(IDX_FQC, d, r);
		repeat (1700) @(posedge clk);
		wr(IDX_FQC, 16'h00f1);
		rc("flag kept", IDX_FQC, 16'h00f1);
	endtask

	task automatic t_dead;
		logic [31:0] d;
		logic [1:0]  r;
		wr(IDX_FQC, 16'h00f2);
		dtime(1'b1, n);
		chk("deadtime div1", 32'd3, n);
		rd(IDX_CTRL, d, r);
		wr(IDX_CTRL, 16'h001f);
		repeat (1700) @(posedge clk);
		rc("ldok auto clear", IDX_CTRL, 16'h0017);
		dtime(1'b0, n);
		chk("deadtime div2", 32'd5, n);
		wr(IDX_CTRL, 16'h0037);
		wr(IDX_DTM, 16'h0007);
		rc("deadtime locked", IDX_DTM, 16'h0003);
		chk("overlap", 32'h0000_0000, {31'h0000_0000, shootThru});
	endtask

	// center mode with half-cycle reloads: one reload per modulus
	task automatic t_center;
		logic [31:0] d;
		logic [1:0]  r;
		wr(IDX_FQC, 16'h0008);
		wr(IDX_MOD, 16'h0028);
		rd(IDX_CTRL, d, r);
		wr(IDX_CTRL, 16'h003b);
		repeat (3600) @(posedge clk);
		rc("center ldok", IDX_CTRL, 16'h0033);
		for (int i = 0; i < 3; i++) begin
			rd(IDX_FQC, d, r);
			wr(IDX_FQC, 16'h0009);
			a = b;
			wait_irq();
			b = cyc;
		end
		chk("half reload spacing", 32'h0000_0028, b - a);
	endtask

	initial begin
		rstn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, pairDrive} = 6'h00;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_gate();
		t_flag();
		t_dead();
		t_center();
		close_out();
	end

	// whole run needs well under 20000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule
